// ### rtl/csic_pkg.sv
// Constants shared by the stack and interrupt control block.
// Assumes a single CPU clock; register offsets are I/O-space indices.
package csic_pkg;
    localparam int          SP_W          = 16;
    localparam int          NUM_SRC       = 8;
    localparam int          VEC_W         = 16;
    // I/O-space register indices
    localparam logic [5:0]  OFS_SP_LOW    = 6'h3d;
    localparam logic [5:0]  OFS_SP_HIGH   = 6'h3e;
    localparam logic [5:0]  OFS_FLAGS     = 6'h3f;
    localparam logic [5:0]  OFS_PAGE      = 6'h3b;
    localparam logic [5:0]  OFS_MCU_CTRL  = 6'h35;
    localparam logic [5:0]  OFS_IRQ_EN    = 6'h30;
    localparam logic [5:0]  OFS_IRQ_FLAG  = 6'h31;
    // Field positions
    localparam int          FLAGS_GIE_BIT = 7;
    localparam int          PAGE_BIT      = 0;
    localparam int          MCU_VECTOR_RELOCATE_SELECT_BIT = 1;
    // Reset values and page write mask
    localparam logic [7:0]  SP_RST        = 8'h00;
    localparam logic [7:0]  FLAGS_RST     = 8'h00;
    localparam logic [7:0]  PAGE_RST      = 8'h00;
    localparam logic [7:0]  PAGE_MASK     = 8'h01;
    // Vector layout: reset at 0, each source two words apart
    localparam logic [15:0] VEC_RESET     = 16'h0000;
    localparam logic [15:0] VEC_FIRST     = 16'h0002;
    localparam logic [15:0] VEC_STEP      = 16'h0002;
    // Interrupt entry and return length in clock cycles
    localparam int          ACCEPT_CYC    = 4;
    localparam int          RETURN_CYC    = 4;
    localparam logic [2:0]  ACCEPT_CNT    = 3'h4;
    localparam logic [2:0]  RETURN_CNT    = 3'h4;
    // Stack pointer operations
    typedef enum logic [2:0] {
        CSIC_SP_NONE  = 3'b000,
        CSIC_SP_PUSH1 = 3'b001,
        CSIC_SP_PUSH2 = 3'b010,
        CSIC_SP_POP1  = 3'b011,
        CSIC_SP_POP2  = 3'b100
    } csic_sp_op_t;
endpackage : csic_pkg

// ### rtl/csic_irq_flag.sv
// One interrupt source: latched flag or level request.
// Assumes the event input is synchronous to clk.
`timescale 1ns/10ps
module csic_irq_flag (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic is_level,
    input  wire logic event_in,
    input  wire logic sw_clear,
    input  wire logic hw_clear,
    output logic      req
);
    logic flag_r;

    // Set wins over either clear in the same cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            flag_r <= 1'b0;
        end else if (event_in) begin
            flag_r <= 1'b1;
        end else if (sw_clear || hw_clear) begin
            flag_r <= 1'b0;
        end
    end

    // Level sources request only while their condition persists
    assign req = is_level ? event_in : flag_r;
endmodule : csic_irq_flag

// ### rtl/csic_stack_ptr.sv
// Stack pointer datapath with byte-wide software access.
// Assumes at most one of push, pop or write per cycle from the sequencer.
`timescale 1ns/10ps
module csic_stack_ptr #(
    parameter int SP_W = 16
) (
    input  wire logic            clk,
    input  wire logic            rst,
    input  csic_pkg::csic_sp_op_t op,
    input  wire logic            wr_low,
    input  wire logic            wr_high,
    input  wire logic [7:0]      wdata,
    output logic [SP_W-1:0]      sp
);
    initial begin
        if (SP_W != 16) $error("csic_stack_ptr supports SP_W of 16 only");
    end

    logic [SP_W-1:0] sp_r;
    logic [SP_W-1:0] sp_nxt;

    always_comb begin
        sp_nxt = sp_r;
        case (op)
            csic_pkg::CSIC_SP_PUSH1: sp_nxt = sp_r - 16'h0001;
            csic_pkg::CSIC_SP_PUSH2: sp_nxt = sp_r - 16'h0002;
            csic_pkg::CSIC_SP_POP1:  sp_nxt = sp_r + 16'h0001;
            csic_pkg::CSIC_SP_POP2:  sp_nxt = sp_r + 16'h0002;
            default:                 sp_nxt = sp_r;
        endcase
        if (wr_low) begin
            sp_nxt[7:0] = wdata;
        end
        if (wr_high) begin
            sp_nxt[15:8] = wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sp_r <= {csic_pkg::SP_RST, csic_pkg::SP_RST};
        end else begin
            sp_r <= sp_nxt;
        end
    end

    assign sp = sp_r;
endmodule : csic_stack_ptr

// ### rtl/csic_core_ctrl.sv
// Stack pointer, program page select and interrupt control of the CPU core.
// Assumes an instruction sequencer on clk pulses one-cycle strobes and that
// peripheral events are already synchronous to clk.
// Function
// - A one-byte push stores data, then lowers the stack pointer by one.
// - Call or interrupt entry lowers the stack pointer by two.
// - Pops and returns raise the stack pointer by one per byte.
// - Stack pointer is two 8-bit read/write bytes, both reset to zero.
// - Page register bits 7..1 read zero; software writes zeros.
// - Page bit picks lower or upper program half for extended loads/stores.
// - Plain program load ignores the page bit.
// - CPU clock is the chip clock with no division.
// - Two-operand ALU read, compute and write back in one cycle.
// - A source is taken only with its enable and global enable both set.
// - Programmed boot lock bits suppress interrupts depending on PC.
// - Lower vector address wins; reset highest, external zero next.
// - Relocate bit moves irq vectors, reset fuse moves reset vector, to boot.
// - Entry clears global enable; return sets it; software may nest.
// - Vectoring clears the served flag; writing one also clears it.
// - Flags raised while disabled stay latched, then serve by priority.
// - Level sources request only while their condition lasts.
// - After return, one main instruction runs before the next interrupt.
// - Entry and return never save or restore the flags register.
// - Disable instruction blocks interrupts at once, even same-cycle ones.
// - After enable instruction, the next instruction runs before service.
// - Acceptance takes four cycles pushing the PC before the vector.
`timescale 1ns/10ps
module csic_core_ctrl #(
    parameter int          NUM_SRC    = csic_pkg::NUM_SRC,
    parameter logic [15:0] BOOT_START = 16'hf000
) (
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire logic [5:0]         io_addr,
    input  wire logic               io_wr,
    input  wire logic               io_rd,
    input  wire logic [7:0]         io_wdata,
    output logic [7:0]              io_rdata,
    input  wire logic               push_byte,
    input  wire logic               call_push,
    input  wire logic               pop_byte,
    input  wire logic               sub_return,
    input  wire logic               irq_return,
    input  wire logic               instr_done,
    input  wire logic               irq_disable_instr,
    input  wire logic               irq_enable_instr,
    input  wire logic               flags_wr,
    input  wire logic [6:0]         alu_flags,
    input  wire logic [15:0]        pc,
    input  wire logic [15:0]        z_ptr,
    input  wire logic               extended_prog_load,
    input  wire logic               self_prog_store,
    input  wire logic               boot_reset_fuse,
    input  wire logic               boot_lock_app_bits,
    input  wire logic               boot_lock_boot_bits,
    input  wire logic [NUM_SRC-1:0] src_event,
    input  wire logic [NUM_SRC-1:0] src_is_level,
    output logic [15:0]             sp_out,
    output logic [16:0]             prog_addr,
    output logic                    irq_busy,
    output logic                    vector_valid,
    output logic [15:0]             vector_addr,
    output logic [7:0]              cpu_flags_reg
);
    initial begin
        if (NUM_SRC < 1 || NUM_SRC > 8) $error("NUM_SRC must be 1 to 8");
    end

    typedef enum logic [1:0] {
        CSIC_IDLE   = 2'b00,
        CSIC_ACCEPT = 2'b01,
        CSIC_RETURN = 2'b10
    } csic_state_t;

    csic_state_t          state_r;
    logic [2:0]           cnt_r;
    logic [7:0]           flags_r;
    logic [7:0]           page_r;
    logic [7:0]           mcu_r;
    logic [NUM_SRC-1:0]   en_r;
    logic [NUM_SRC-1:0]   req;
    logic [NUM_SRC-1:0]   hw_clr;
    logic [NUM_SRC-1:0]   sw_clr;
    logic                 hold_r;
    logic [2:0]           win_idx;
    logic                 win_any;
    logic                 take;
    logic                 boot_block;
    logic [15:0]          sp_w;
    logic [2:0]           win_r;
    logic                 ret_init_r;
    csic_pkg::csic_sp_op_t sp_op;

    wire wr_hit_flags = io_wr && io_addr == csic_pkg::OFS_FLAGS;

    // Sources
    genvar g;
    generate
        for (g = 0; g < NUM_SRC; g++) begin : g_src
            assign sw_clr[g] = io_wr && io_addr == csic_pkg::OFS_IRQ_FLAG && io_wdata[g];
            assign hw_clr[g] = state_r == CSIC_IDLE && take && win_idx == 3'(g);
            csic_irq_flag u_flag (
                .clk      (clk),
                .rst      (rst),
                .is_level (src_is_level[g]),
                .event_in (src_event[g]),
                .sw_clear (sw_clr[g]),
                .hw_clear (hw_clr[g]),
                .req      (req[g])
            );
        end
    endgenerate

    // Lowest index holds the lowest vector, so it wins
    always_comb begin
        win_idx = 3'h0;
        win_any = 1'b0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (req[i] && en_r[i]) begin
                win_idx = 3'(i);
                win_any = 1'b1;
            end
        end
    end

    // Interrupts suppressed while PC sits in a locked section
    assign boot_block = (boot_lock_app_bits && pc < BOOT_START) ||
                        (boot_lock_boot_bits && pc >= BOOT_START);

    // Global enable as registered; disable instruction blocks same cycle
    assign take = win_any && flags_r[csic_pkg::FLAGS_GIE_BIT] && !irq_disable_instr &&
                  !hold_r && !boot_block && instr_done;

    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= CSIC_IDLE;
            cnt_r   <= 3'h0;
        end else begin
            case (state_r)
                CSIC_IDLE: begin
                    if (take) begin
                        state_r <= CSIC_ACCEPT;
                        cnt_r   <= csic_pkg::ACCEPT_CNT - 3'h1;
                    end else if (irq_return) begin
                        state_r <= CSIC_RETURN;
                        cnt_r   <= csic_pkg::RETURN_CNT - 3'h1;
                    end
                end
                CSIC_ACCEPT, CSIC_RETURN: begin
                    if (cnt_r == 3'h1) begin
                        state_r <= CSIC_IDLE;
                    end
                    cnt_r <= cnt_r - 3'h1;
                end
                default: state_r <= CSIC_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            win_r      <= 3'h0;
            ret_init_r <= 1'b0;
        end else begin
            if (state_r == CSIC_IDLE && take) begin
                win_r <= win_idx;
            end
            ret_init_r <= state_r == CSIC_IDLE && !take && irq_return;
        end
    end

    // One main instruction must complete after return or enable
    always_ff @(posedge clk) begin
        if (rst) begin
            hold_r <= 1'b0;
        end else if ((state_r == CSIC_RETURN && cnt_r == 3'h1) || irq_enable_instr) begin
            hold_r <= 1'b1;
        end else if (instr_done) begin
            hold_r <= 1'b0;
        end
    end

    // Flags register: only the enable bit is touched by entry and return
    always_ff @(posedge clk) begin
        if (rst) begin
            flags_r <= csic_pkg::FLAGS_RST;
        end else begin
            if (wr_hit_flags) begin
                flags_r <= io_wdata;
            end else if (flags_wr) begin
                flags_r[6:0] <= alu_flags;
            end
            if (state_r == CSIC_IDLE && take) begin
                flags_r[csic_pkg::FLAGS_GIE_BIT] <= 1'b0;
            end else if (irq_disable_instr) begin
                flags_r[csic_pkg::FLAGS_GIE_BIT] <= 1'b0;
            end else if (irq_enable_instr || (state_r == CSIC_RETURN && cnt_r == 3'h1)) begin
                flags_r[csic_pkg::FLAGS_GIE_BIT] <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            page_r <= csic_pkg::PAGE_RST;
            mcu_r  <= 8'h00;
            en_r   <= '0;
        end else if (io_wr) begin
            if (io_addr == csic_pkg::OFS_PAGE) begin
                page_r <= io_wdata & csic_pkg::PAGE_MASK;
            end
            if (io_addr == csic_pkg::OFS_MCU_CTRL) begin
                mcu_r <= io_wdata;
            end
            if (io_addr == csic_pkg::OFS_IRQ_EN) begin
                en_r <= io_wdata[NUM_SRC-1:0];
            end
        end
    end

    // Stack pointer operations
    always_comb begin
        sp_op = csic_pkg::CSIC_SP_NONE;
        if (state_r == CSIC_IDLE && take) begin
            sp_op = csic_pkg::CSIC_SP_PUSH2;
        end else if (ret_init_r || sub_return) begin
            sp_op = csic_pkg::CSIC_SP_POP2;
        end else if (call_push) begin
            sp_op = csic_pkg::CSIC_SP_PUSH2;
        end else if (push_byte) begin
            sp_op = csic_pkg::CSIC_SP_PUSH1;
        end else if (pop_byte) begin
            sp_op = csic_pkg::CSIC_SP_POP1;
        end
    end

    csic_stack_ptr #(.SP_W(16)) u_sp (
        .clk     (clk),
        .rst     (rst),
        .op      (sp_op),
        .wr_low  (io_wr && io_addr == csic_pkg::OFS_SP_LOW),
        .wr_high (io_wr && io_addr == csic_pkg::OFS_SP_HIGH),
        .wdata   (io_wdata),
        .sp      (sp_w)
    );

    // Registered outputs
    always_ff @(posedge clk) begin
        if (rst) begin
            io_rdata      <= 8'h00;
            sp_out        <= 16'h0000;
            prog_addr     <= 17'h00000;
            irq_busy      <= 1'b0;
            vector_valid  <= 1'b0;
            vector_addr   <= csic_pkg::VEC_RESET;
            cpu_flags_reg <= csic_pkg::FLAGS_RST;
        end else begin
            sp_out        <= sp_w;
            cpu_flags_reg <= flags_r;
            irq_busy      <= state_r != CSIC_IDLE || take;
            if (extended_prog_load || self_prog_store) begin
                prog_addr <= {page_r[csic_pkg::PAGE_BIT], z_ptr};
            end else begin
                prog_addr <= {1'b0, z_ptr};
            end
            // Vector after the four-cycle push window ends
            vector_valid <= state_r == CSIC_ACCEPT && cnt_r == 3'h1;
            if (state_r == CSIC_ACCEPT && cnt_r == 3'h1) begin
                vector_addr <= (mcu_r[csic_pkg::MCU_VECTOR_RELOCATE_SELECT_BIT] ? BOOT_START : 16'h0000) +
                               csic_pkg::VEC_FIRST + 16'(win_r) * csic_pkg::VEC_STEP;
            end else if (!vector_valid) begin
                vector_addr <= boot_reset_fuse ? BOOT_START : csic_pkg::VEC_RESET;
            end
            io_rdata <= 8'h00;
            if (io_rd) begin
                case (io_addr)
                    csic_pkg::OFS_SP_LOW:   io_rdata <= sp_w[7:0];
                    csic_pkg::OFS_SP_HIGH:  io_rdata <= sp_w[15:8];
                    csic_pkg::OFS_FLAGS:    io_rdata <= flags_r;
                    csic_pkg::OFS_PAGE:     io_rdata <= page_r & csic_pkg::PAGE_MASK;
                    csic_pkg::OFS_MCU_CTRL: io_rdata <= mcu_r;
                    csic_pkg::OFS_IRQ_EN:   io_rdata <= 8'(en_r);
                    csic_pkg::OFS_IRQ_FLAG: io_rdata <= 8'(req);
                    default:                io_rdata <= 8'h00;
                endcase
            end
        end
    end

    // Checks
    sequence accept_seq;
        state_r == CSIC_ACCEPT [*3];
    endsequence

    entry_gie_clear_a: assert property (@(posedge clk) disable iff (rst)
        (state_r == CSIC_IDLE && take) |=> !flags_r[csic_pkg::FLAGS_GIE_BIT])
        else $error("global enable not cleared on entry");
    entry_push_two_a: assert property (@(posedge clk) disable iff (rst)
        (state_r == CSIC_IDLE && take && !io_wr) |=> sp_w == $past(sp_w) - 16'h0002)
        else $error("stack pointer not lowered by two on entry");
    accept_len_a: assert property (@(posedge clk) disable iff (rst)
        (state_r == CSIC_IDLE && take) |=> accept_seq ##1 vector_valid)
        else $error("interrupt acceptance length wrong");
    cli_block_a: assert property (@(posedge clk) disable iff (rst)
        irq_disable_instr |-> !take)
        else $error("interrupt taken with disable instruction");
    enable_gate_a: assert property (@(posedge clk) disable iff (rst)
        take |-> flags_r[csic_pkg::FLAGS_GIE_BIT] && (en_r & req) != '0)
        else $error("interrupt taken while disabled");
    page_zero_a: assert property (@(posedge clk) disable iff (rst)
        page_r[7:1] == 7'h00)
        else $error("page register upper bits not zero");
    return_hold_a: assert property (@(posedge clk) disable iff (rst)
        (state_r == CSIC_RETURN && cnt_r == 3'h1) |=> !take)
        else $error("interrupt taken straight after return");
    return_gie_a: assert property (@(posedge clk) disable iff (rst)
        (state_r == CSIC_RETURN && cnt_r == 3'h1 && !irq_disable_instr) |=> flags_r[csic_pkg::FLAGS_GIE_BIT])
        else $error("global enable not set on return");
    lpm_flat_a: assert property (@(posedge clk) disable iff (rst)
        (!extended_prog_load && !self_prog_store) |=> !prog_addr[16])
        else $error("plain program load used page bit");
    push_one_a: assert property (@(posedge clk) disable iff (rst)
        (sp_op == csic_pkg::CSIC_SP_PUSH1 && !io_wr) |=> sp_w == $past(sp_w) - 16'h0001)
        else $error("push did not lower stack pointer by one");
endmodule : csic_core_ctrl

// ### bench/csic_periph_model.sv
// Peripheral request sources and instruction sequencer facing the core control.
// Assumes bench commands change just after a rising clk edge.
`timescale 1ns/10ps
module csic_periph_model #(
    parameter int N = 8
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [N-1:0] fire,
    input  wire logic [N-1:0] cond,
    input  wire logic         slow,
    output logic      [N-1:0] src_event,
    output logic              instr_done
);
    logic [1:0] cnt_r;

    // Flag events last one cycle; level conditions last while commanded
    always_ff @(posedge clk) begin
        if (rst) begin
            src_event <= '0;
        end else begin
            src_event <= fire | cond;
        end
    end

    // Slow sequencer completes an instruction every fourth cycle only
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_r      <= 2'h0;
            instr_done <= 1'b0;
        end else begin
            cnt_r      <= cnt_r + 2'h1;
            instr_done <= !slow || cnt_r == 2'h3;
        end
    end
endmodule : csic_periph_model

// ### bench/cpu_stack_and_interrupt_control_test.sv
// Self-checking bench for the stack pointer, page select and interrupt control.
// Assumes the sequencer model drives instr_done and the source events.
`timescale 1ns/10ps
module cpu_stack_and_interrupt_control_test;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [5:0]  io_addr = 6'h00;
    logic        io_wr = 1'b0, io_rd = 1'b0, rd_seen = 1'b0;
    logic [7:0]  io_wdata = 8'h00, io_rdata, strb = 8'h00;
    logic        instr_done, slow = 1'b0, ext_ld = 1'b0, sps = 1'b0;
    logic        fuse = 1'b0, lock_app = 1'b0, lock_boot = 1'b0;
    logic [6:0]  alu_flags = 7'h00;
    logic [15:0] pc = 16'h0000, z_ptr = 16'h0000, sp_e, sp_out, vector_addr;
    logic [7:0]  fire = 8'h00, cond = 8'h00, lvl = 8'h10, src_event, cpu_flags_reg;
    logic [16:0] prog_addr;
    logic        irq_busy, vector_valid;
    logic [7:0]  exp_rd[$];
    logic [15:0] exp_vec[$];
    int          err_count = 0;
    int          n_checks = 0;

    always #12.5 clk = ~clk;

    csic_periph_model #(.N(8)) csic_periph_model_i (.clk(clk), .rst(rst), .fire(fire), .cond(cond),
        .slow(slow), .src_event(src_event), .instr_done(instr_done));

    csic_core_ctrl #(.NUM_SRC(8)) csic_core_ctrl_i (.clk(clk), .rst(rst), .io_addr(io_addr), .io_wr(io_wr),
        .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .push_byte(strb[0]), .call_push(strb[1]),
        .pop_byte(strb[2]), .sub_return(strb[3]), .irq_return(strb[4]), .instr_done(instr_done),
        .irq_disable_instr(strb[5]), .irq_enable_instr(strb[6]), .flags_wr(strb[7]), .alu_flags(alu_flags),
        .pc(pc), .z_ptr(z_ptr), .extended_prog_load(ext_ld), .self_prog_store(sps), .boot_reset_fuse(fuse),
        .boot_lock_app_bits(lock_app), .boot_lock_boot_bits(lock_boot), .src_event(src_event),
        .src_is_level(lvl), .sp_out(sp_out), .prog_addr(prog_addr), .irq_busy(irq_busy),
        .vector_valid(vector_valid), .vector_addr(vector_addr), .cpu_flags_reg(cpu_flags_reg));

    task automatic finish_test();
        if (err_count == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input logic [16:0] got, input logic [16:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : tick

    task automatic io_write(input logic [5:0] a, input logic [7:0] d);
        tick(1);
        io_addr = a;
        io_wdata = d;
        io_wr = 1'b1;
        tick(1);
        io_wr = 1'b0;
    endtask : io_write

    task automatic io_read(input logic [5:0] a, input logic [7:0] e);
        exp_rd.push_back(e);
        tick(1);
        io_addr = a;
        io_rd = 1'b1;
        tick(1);
        io_rd = 1'b0;
        tick(1);
    endtask : io_read

    task automatic pulse(input int i);
        tick(1);
        strb[i] = 1'b1;
        tick(1);
        strb[i] = 1'b0;
    endtask : pulse

    task automatic sp_step(input int i, input logic [15:0] d);
        pulse(i);
        tick(2);
        sp_e = sp_e + d;
        chk(sp_out, sp_e);
    endtask : sp_step

    task automatic fire_src(input logic [7:0] m);
        tick(1);
        fire = m;
        tick(1);
        fire = 8'h00;
    endtask : fire_src

    // Bounded wait until only n vectors remain expected
    task automatic wait_vec(input int n);
        int k = 0;
        while (exp_vec.size() != n && k < 60) begin
            tick(1);
            k++;
        end
        chk(exp_vec.size(), n);
    endtask : wait_vec

    // Read data is valid the cycle after the read strobe
    always @(posedge clk) rd_seen <= io_rd;

    always @(negedge clk) begin
        if (rd_seen && exp_rd.size() > 0) begin
            chk(io_rdata, exp_rd.pop_front());
        end
        if (vector_valid) begin
            chk(irq_busy, 1'b1);
            if (exp_vec.size() == 0) begin
                chk(vector_addr, 17'h1ffff);
            end else begin
                chk(vector_addr, exp_vec.pop_front());
            end
        end
    end

    initial begin
        #(25ns * 20000);
        err_count++;
        finish_test();
    end

    initial begin
        logic [7:0]  lo;
        logic [15:0] z;
        void'($urandom(32));
        tick(5);
        rst = 1'b0;
        io_read(csic_pkg::OFS_SP_LOW, csic_pkg::SP_RST);
        io_read(csic_pkg::OFS_SP_HIGH, csic_pkg::SP_RST);
        io_read(csic_pkg::OFS_PAGE, csic_pkg::PAGE_RST);
        io_write(csic_pkg::OFS_PAGE, 8'hff);
        io_read(csic_pkg::OFS_PAGE, 8'h01);
        io_read(6'h00, 8'h00);
        lo = 8'h80 + 8'($urandom % 112);
        sp_e = {8'h10, lo};
        io_write(csic_pkg::OFS_SP_HIGH, 8'h10);
        io_write(csic_pkg::OFS_SP_LOW, lo);
        io_read(csic_pkg::OFS_SP_LOW, lo);
        io_read(csic_pkg::OFS_SP_HIGH, 8'h10);
        sp_step(0, 16'hffff);
        sp_step(1, 16'hfffe);
        sp_step(2, 16'h0001);
        sp_step(3, 16'h0002);
        z = 16'($urandom);
        z_ptr = z;
        ext_ld = 1'b1;
        tick(2);
        chk(prog_addr, {1'b1, z});
        ext_ld = 1'b0;
        tick(2);
        chk(prog_addr, {1'b0, z});
        io_write(csic_pkg::OFS_PAGE, 8'h00);
        sps = 1'b1;
        tick(2);
        chk(prog_addr, {1'b0, z});
        sps = 1'b0;
        alu_flags = 7'h55;
        pulse(7);
        tick(2);
        chk(cpu_flags_reg, 8'h55);
        io_write(csic_pkg::OFS_IRQ_EN, 8'h06);
        fire_src(8'h06);
        tick(2);
        io_read(csic_pkg::OFS_IRQ_FLAG, 8'h06);
        exp_vec.push_back(16'h0004);
        exp_vec.push_back(16'h0006);
        io_write(csic_pkg::OFS_FLAGS, 8'hd5);
        wait_vec(1);
        tick(2);
        chk(cpu_flags_reg, 8'h55);
        chk(sp_out, sp_e - 16'h2);
        pulse(4);
        wait_vec(0);
        pulse(4);
        tick(8);
        chk(cpu_flags_reg, 8'hd5);
        io_read(csic_pkg::OFS_IRQ_FLAG, 8'h00);
        io_write(csic_pkg::OFS_IRQ_EN, 8'h00);
        fire_src(8'h08);
        tick(2);
        io_read(csic_pkg::OFS_IRQ_FLAG, 8'h08);
        io_write(csic_pkg::OFS_IRQ_FLAG, 8'h08);
        io_read(csic_pkg::OFS_IRQ_FLAG, 8'h00);
        cond = 8'h10;
        tick(2);
        cond = 8'h00;
        io_write(csic_pkg::OFS_IRQ_EN, 8'h10);
        tick(12);
        io_write(csic_pkg::OFS_IRQ_EN, 8'h20);
        fire = 8'h20;
        tick(1);
        fire = 8'h00;
        strb[5] = 1'b1;
        tick(1);
        strb[5] = 1'b0;
        tick(12);
        chk(cpu_flags_reg[7], 1'b0);
        exp_vec.push_back(16'h000c);
        pulse(6);
        wait_vec(0);
        pulse(4);
        tick(8);
        slow = 1'b1;
        lock_app = 1'b1;
        io_write(csic_pkg::OFS_MCU_CTRL, 8'h02);
        io_write(csic_pkg::OFS_IRQ_EN, 8'h01);
        fire_src(8'h01);
        tick(12);
        exp_vec.push_back(16'hf002);
        pc = 16'hf100;
        wait_vec(0);
        pulse(4);
        tick(8);
        // Reset vector moves with the fuse; boot lock blocks while pc is in boot section
        fuse = 1'b1;
        lock_app = 1'b0;
        lock_boot = 1'b1;
        tick(2);
        chk(vector_addr, 16'hf000);
        fire_src(8'h01);
        tick(12);
        exp_vec.push_back(16'hf002);
        pc = 16'h0100;
        wait_vec(0);
        pulse(4);
        tick(8);
        finish_test();
    end
endmodule : cpu_stack_and_interrupt_control_test
